// [core/adc_cal_cfg.svh]
`ifndef ADC_CAL_CFG_SVH
`define ADC_CAL_CFG_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define ADDR_CONFIG        4'h0
`define ADDR_CAL_ADJUST    4'h4
`define ADDR_CAL_VALUES    4'h5
`define BIT_CAL_REQUEST    15
`define BIT_PD_FIRST       11
`define BIT_PD_SECOND      10
`define BIT_SEQ_SELECT     14
`define BIT_STORE_ACCESS   7
`define RST_SEQ_SELECT     1'b1
`define RST_STORE_ACCESS   1'b0

// ------------------------------------------------------------
// Constant store layout
// ------------------------------------------------------------
`define STORE_FIRST        8'h01
`define STORE_LAST         8'hEF

// ------------------------------------------------------------
// Timing, in sampling clock cycles
// ------------------------------------------------------------
`define REQ_LOW_CYCLES     16'h0050
`define REQ_HIGH_CYCLES    16'h0050
`define FLUSH_CYCLES       8'h3C
`define TERM_TRIM_CYCLES   32'h0000_4000
`define LIN_TRIM_CYCLES    32'h0001_0000
`define STARTUP_SHORT_DEF  32'h0100_0000
`define STARTUP_LONG_DEF   32'h4000_0000

`endif

// [core/adc_cal_pkg.sv]
package adc_cal_pkg;

	// Register access from the serial interface decoder
	typedef struct packed {
		logic        write;
		logic        read;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	// Asynchronous control pins
	typedef struct packed {
		logic calRequest;
		logic startupDelaySelect;
		logic powerdownFirstChannel;
		logic powerdownSecondChannel;
		logic extendedControlMode;
	} cal_pins_t;

	typedef enum logic [1:0] {
		IDLE,
		TERM_TRIM,
		LIN_TRIM
	} cal_state_t;

endpackage : adc_cal_pkg

// [core/adc_calibration_sequencer.sv]
// Behaviour
// - Qualify request with minimum low/high counts.
// - Extended mode: request is pin OR bit 15.
// - Busy output high exactly while calibrating.
// - Startup calibration after selectable delay.
// - Delay-select change relaunches startup calibration, unless request is high.
// - Request high at power-on skips startup calibration.
// - Sequence select bit 14, default termination plus linearity.
// - Constants array behind values register at 5.
// - Readout: store access, 240 reads, first dummy.
// - Restore: 239 writes, two dummy writes.
// - Both channels down freezes calibration, resume later.
// - Same procedure for every launch source.
// - Outputs low during calibration, valid 60 after.
// - Extended mode: power-down is pin OR register.
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"

module adc_calibration_sequencer
	import adc_cal_pkg::*;
#(
	parameter logic [31:0] STARTUP_SHORT_CYCLES = `STARTUP_SHORT_DEF,
	parameter logic [31:0] STARTUP_LONG_CYCLES  = `STARTUP_LONG_DEF,
	parameter logic [31:0] TERM_CYCLES          = `TERM_TRIM_CYCLES,
	parameter logic [31:0] LIN_CYCLES           = `LIN_TRIM_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire cal_pins_t   pins,
	input  wire reg_req_t    regReq,
	output logic [15:0]      regRdata,
	output logic             regRvalid,
	input  wire logic        trimResultValid,
	input  wire logic [15:0] trimResultData,
	output logic             trimInProgress,
	output logic             termTrimActive,
	output logic             linearityTrimActive,
	output logic             outputsForcedLow,
	output logic             outputDataValid,
	output logic             firstChannelDown,
	output logic             secondChannelDown,
	output logic             deviceSuspended
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [4:0] pinMeta_r;
	logic [4:0] pinSync_r;

	// Pins are asynchronous to the sampling clock
	always_ff @(posedge clock) begin
		if (rst) begin
			pinMeta_r <= 5'h00;
			pinSync_r <= 5'h00;
		end else begin
			pinMeta_r <= pins;
			pinSync_r <= pinMeta_r;
		end
	end

	logic reqPin;
	logic delaySel;
	logic pdPinFirst;
	logic pdPinSecond;
	logic extMode;
	assign {reqPin, delaySel, pdPinFirst, pdPinSecond, extMode} = pinSync_r;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic       calRequestBit_r;
	logic       pdFirstBit_r;
	logic       pdSecondBit_r;
	logic       seqSelect_r;
	logic       storeAccess_r;
	cal_state_t state_r;

	logic wrConfig;
	logic wrAdjust;
	logic wrValues;
	logic rdValues;
	assign wrConfig = regReq.write && regReq.addr == `ADDR_CONFIG;
	assign wrAdjust = regReq.write && regReq.addr == `ADDR_CAL_ADJUST;
	assign wrValues = regReq.write && regReq.addr == `ADDR_CAL_VALUES;
	assign rdValues = regReq.read && regReq.addr == `ADDR_CAL_VALUES;

	// Control bits written by software
	always_ff @(posedge clock) begin
		if (rst) begin
			calRequestBit_r <= 1'b0;
			pdFirstBit_r    <= 1'b0;
			pdSecondBit_r   <= 1'b0;
			seqSelect_r     <= `RST_SEQ_SELECT;
			storeAccess_r   <= `RST_STORE_ACCESS;
		end else if (wrConfig) begin
			calRequestBit_r <= regReq.wdata[`BIT_CAL_REQUEST];
			pdFirstBit_r    <= regReq.wdata[`BIT_PD_FIRST];
			pdSecondBit_r   <= regReq.wdata[`BIT_PD_SECOND];
		end else if (wrAdjust) begin
			seqSelect_r     <= regReq.wdata[`BIT_SEQ_SELECT];
			storeAccess_r   <= regReq.wdata[`BIT_STORE_ACCESS];
		end
	end

	// ------------------------------------------------------------
	// Effective request and power-down
	// ------------------------------------------------------------
	logic effRequest;
	logic bothDown;
	assign effRequest = reqPin | (extMode & calRequestBit_r);
	assign firstChannelDown  = pdPinFirst | (extMode & pdFirstBit_r);
	assign secondChannelDown = pdPinSecond | (extMode & pdSecondBit_r);
	assign bothDown = firstChannelDown & secondChannelDown;

	// ------------------------------------------------------------
	// Request qualification
	// ------------------------------------------------------------
	logic [15:0] lowCount_r;
	logic [15:0] highCount_r;
	logic        lowSeen_r;
	logic        running;
	logic        cmdLaunch;

	assign running = state_r != IDLE;
	// Fires once, when the high phase reaches its minimum after a valid low
	assign cmdLaunch = lowSeen_r && effRequest && !running
		&& highCount_r == `REQ_HIGH_CYCLES - 16'h0001;

	// Noise pulses shorter than the minimum restart the count
	always_ff @(posedge clock) begin
		if (rst) begin
			lowCount_r  <= 16'h0000;
			highCount_r <= 16'h0000;
			lowSeen_r   <= 1'b0;
		end else if (effRequest) begin
			lowCount_r <= 16'h0000;
			if (highCount_r != `REQ_HIGH_CYCLES)
				highCount_r <= highCount_r + 16'h0001;
			if (cmdLaunch)
				lowSeen_r <= 1'b0;
		end else begin
			highCount_r <= 16'h0000;
			if (lowCount_r != `REQ_LOW_CYCLES)
				lowCount_r <= lowCount_r + 16'h0001;
			else if (!running)
				lowSeen_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Startup calibration delay
	// ------------------------------------------------------------
	logic [31:0] startupCount_r;
	logic        startupPending_r;
	logic        delaySelPrev_r;
	logic        startupLaunch;
	logic [31:0] startupTarget;

	assign startupTarget = delaySel ? STARTUP_LONG_CYCLES : STARTUP_SHORT_CYCLES;
	assign startupLaunch = startupPending_r && !running && startupCount_r >= startupTarget;

	// A request held high cancels the pending startup run
	always_ff @(posedge clock) begin
		if (rst) begin
			startupCount_r   <= 32'h0000_0000;
			startupPending_r <= 1'b1;
			delaySelPrev_r   <= 1'b0;
		end else begin
			delaySelPrev_r <= delaySel;
			if (effRequest) begin
				startupPending_r <= 1'b0;
				startupCount_r   <= 32'h0000_0000;
			end else if (delaySel != delaySelPrev_r) begin
				startupPending_r <= 1'b1;
				startupCount_r   <= 32'h0000_0000;
			end else if (startupLaunch) begin
				startupPending_r <= 1'b0;
			end else if (startupPending_r && startupCount_r < startupTarget) begin
				startupCount_r <= startupCount_r + 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------
	// Calibration sequence
	// ------------------------------------------------------------
	logic [31:0] phaseCount_r;
	logic [7:0]  flushCount_r;

	// Every launch source enters the same sequence
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r      <= IDLE;
			phaseCount_r <= 32'h0000_0000;
		end else if (bothDown && running) begin
			state_r <= state_r;
		end else begin
			unique case (state_r)
				IDLE: begin
					phaseCount_r <= 32'h0000_0000;
					if (cmdLaunch || startupLaunch) begin
						state_r      <= seqSelect_r ? TERM_TRIM : LIN_TRIM;
					end
				end
				TERM_TRIM: begin
					if (phaseCount_r == TERM_CYCLES - 32'h0000_0001) begin
						phaseCount_r <= 32'h0000_0000;
						state_r      <= LIN_TRIM;
					end else begin
						phaseCount_r <= phaseCount_r + 32'h0000_0001;
					end
				end
				LIN_TRIM: begin
					if (phaseCount_r == LIN_CYCLES - 32'h0000_0001) begin
						phaseCount_r <= 32'h0000_0000;
						state_r      <= IDLE;
					end else begin
						phaseCount_r <= phaseCount_r + 32'h0000_0001;
					end
				end
			endcase
		end
	end

	assign trimInProgress      = running;
	assign termTrimActive      = state_r == TERM_TRIM && !bothDown;
	assign linearityTrimActive = state_r == LIN_TRIM && !bothDown;
	assign deviceSuspended     = bothDown;

	// Pipeline flush keeps outputs low after the busy flag drops
	always_ff @(posedge clock) begin
		if (rst)
			flushCount_r <= `FLUSH_CYCLES;
		else if (running)
			flushCount_r <= 8'h00;
		else if (flushCount_r != `FLUSH_CYCLES)
			flushCount_r <= flushCount_r + 8'h01;
	end

	assign outputsForcedLow = running || flushCount_r != `FLUSH_CYCLES;
	assign outputDataValid  = !outputsForcedLow;

	// ------------------------------------------------------------
	// Calibration constant store
	// ------------------------------------------------------------
	logic [15:0] constStore [`STORE_FIRST:`STORE_LAST];
	logic [7:0]  readPtr_r;
	logic [7:0]  writePtr_r;
	logic [7:0]  engPtr_r;
	logic        storeAccessPrev_r;
	logic        engWrite;
	logic        hostWrite;

	assign engWrite  = linearityTrimActive && trimResultValid && engPtr_r <= `STORE_LAST;
	assign hostWrite = storeAccess_r && wrValues && writePtr_r <= `STORE_LAST;

	// Host read and write pointers restart each time store access is switched on
	always_ff @(posedge clock) begin
		if (rst) begin
			readPtr_r         <= 8'h00;
			writePtr_r        <= `STORE_FIRST;
			engPtr_r          <= `STORE_FIRST;
			storeAccessPrev_r <= 1'b0;
		end else begin
			storeAccessPrev_r <= storeAccess_r;
			if (storeAccess_r && !storeAccessPrev_r) begin
				readPtr_r  <= 8'h00;
				writePtr_r <= `STORE_FIRST;
			end else begin
				if (storeAccess_r && rdValues && readPtr_r <= `STORE_LAST)
					readPtr_r <= readPtr_r + 8'h01;
				if (storeAccess_r && wrValues && writePtr_r <= `STORE_LAST)
					writePtr_r <= writePtr_r + 8'h01;
			end
			if (state_r == IDLE)
				engPtr_r <= `STORE_FIRST;
			else if (engWrite)
				engPtr_r <= engPtr_r + 8'h01;
		end
	end

	// Engine results win; host access while calibrating is unsupported
	always_ff @(posedge clock) begin
		if (engWrite)
			constStore[engPtr_r] <= trimResultData;
		else if (hostWrite)
			constStore[writePtr_r] <= regReq.wdata;
	end

	// ------------------------------------------------------------
	// Register read path
	// ------------------------------------------------------------
	logic [15:0] rdata_nxt;

	// First values read returns a dummy zero word
	always_comb begin
		rdata_nxt = 16'h0000;
		unique case (regReq.addr)
			`ADDR_CONFIG: begin
				rdata_nxt[`BIT_CAL_REQUEST] = calRequestBit_r;
				rdata_nxt[`BIT_PD_FIRST]    = pdFirstBit_r;
				rdata_nxt[`BIT_PD_SECOND]   = pdSecondBit_r;
			end
			`ADDR_CAL_ADJUST: begin
				rdata_nxt[`BIT_SEQ_SELECT]   = seqSelect_r;
				rdata_nxt[`BIT_STORE_ACCESS] = storeAccess_r;
			end
			`ADDR_CAL_VALUES: begin
				if (storeAccess_r && readPtr_r >= `STORE_FIRST && readPtr_r <= `STORE_LAST)
					rdata_nxt = constStore[readPtr_r];
			end
			default: rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			regRdata  <= 16'h0000;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regReq.read;
			if (regReq.read)
				regRdata <= rdata_nxt;
		end
	end

endmodule : adc_calibration_sequencer

// [testbench/adc_calibration_sequencer_props.sv]
`timescale 1ns/10ps
module adc_calibration_sequencer_props
	import adc_cal_pkg::*;
(
	input wire logic      clock,
	input wire logic      rst,
	input wire cal_pins_t pins,
	input wire reg_req_t  regReq,
	input wire logic      regRvalid,
	input wire logic      trimInProgress,
	input wire logic      termTrimActive,
	input wire logic      linearityTrimActive,
	input wire logic      outputsForcedLow,
	input wire logic      outputDataValid,
	input wire logic      firstChannelDown,
	input wire logic      secondChannelDown,
	input wire logic      deviceSuspended
);
	// ----
	// Sequencer checks
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Outputs held low through the run and the flush
	chk_forced_busy: assert property (trimInProgress |-> outputsForcedLow)
		else $error("outputs live in run");
	chk_flush_sixty: assert property
		($fell(trimInProgress) |-> ##59 outputsForcedLow ##1 outputDataValid)
		else $error("flush length wrong");
	chk_phase_excl: assert property
		((termTrimActive || linearityTrimActive) |->
			trimInProgress && !(termTrimActive && linearityTrimActive))
		else $error("phase outside run");
	chk_suspend_frozen: assert property
		(deviceSuspended |-> !termTrimActive && !linearityTrimActive
			&& firstChannelDown && secondChannelDown)
		else $error("suspend wrong");
	chk_busy_holds: assert property ($rose(trimInProgress) |=> trimInProgress [*8])
		else $error("run cut short");
	chk_read_answer: assert property (regRvalid == $past(regReq.read))
		else $error("read valid wrong");
	chk_pd_pin_or: assert property
		(pins.powerdownFirstChannel [*4] |-> firstChannelDown)
		else $error("pin power-down lost");
	chk_term_then_lin: assert property
		($fell(termTrimActive) && trimInProgress && !deviceSuspended |-> linearityTrimActive)
		else $error("phase order wrong");
endmodule : adc_calibration_sequencer_props

bind adc_calibration_sequencer adc_calibration_sequencer_props u_adc_calibration_sequencer_props (
	.clock(clock), .rst(rst), .pins(pins), .regReq(regReq), .regRvalid(regRvalid),
	.trimInProgress(trimInProgress), .termTrimActive(termTrimActive),
	.linearityTrimActive(linearityTrimActive), .outputsForcedLow(outputsForcedLow),
	.outputDataValid(outputDataValid), .firstChannelDown(firstChannelDown),
	.secondChannelDown(secondChannelDown), .deviceSuspended(deviceSuspended)
);

// [testbench/cal_host.sv]
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"
module cal_host
	import adc_cal_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        trimInProgress,
	input  wire logic [15:0] regRdata,
	output cal_pins_t        pins,
	output reg_req_t         regReq
);
	// ----
	// Host pins and serial access
	// ----
	// Extended mode, so the pin and the bit paths are both live
	initial begin
		pins = 5'h01;
		regReq = '0;
	end
	// Serial access waits out a run, since it would spoil the trim
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		while (trimInProgress) @(posedge clock);
		@(posedge clock) #1;
		regReq = {2'h2, a, d};
		@(posedge clock) #1;
		regReq = '0;
	endtask : wr
	// Read data is registered, one cycle behind the request
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		while (trimInProgress) @(posedge clock);
		@(posedge clock) #1;
		regReq = {2'h1, a, 16'h0000};
		@(posedge clock) #1;
		regReq = '0;
		d = regRdata;
	endtask : rd
	// Request low then high; a short high is a noise pulse
	task automatic request(input logic viaBit, input int highLen);
		@(posedge clock) #1;
		pins.calRequest = 1'b0;
		repeat (100) @(posedge clock);
		if (viaBit) wr(`ADDR_CONFIG, 16'h8000);
		else #1 pins.calRequest = 1'b1;
		repeat (highLen) @(posedge clock);
		#1 pins.calRequest = 1'b0;
		if (viaBit) wr(`ADDR_CONFIG, 16'h0000);
	endtask : request
	// Restore framed by store access, dummy writes at the end
	task automatic restore(input logic [15:0] base);
		wr(`ADDR_CAL_ADJUST, 16'h4080);
		for (int i = 1; i < 240; i++) wr(`ADDR_CAL_VALUES, base + 16'(i));
		repeat (2) wr(`ADDR_CAL_VALUES, 16'h0000);
		wr(`ADDR_CAL_ADJUST, 16'h4000);
	endtask : restore
endmodule : cal_host

// [testbench/test_adc_calibration_sequencer.sv]
`timescale 1ns/10ps
`include "adc_cal_cfg.svh"
module test_adc_calibration_sequencer
	import adc_cal_pkg::*;
;
	logic        clock, rst, regRvalid, trimInProgress, termTrimActive, linearityTrimActive;
	logic        outputsForcedLow, outputDataValid, firstChannelDown, secondChannelDown;
	logic        deviceSuspended, trimResultValid;
	logic [15:0] regRdata, rdv, trimResultData;
	cal_pins_t   pins;
	reg_req_t    regReq;
	int          n_errors = 0, total_checks = 0, cycles = 0, sinceRst = 0, busyLen = 0;
	int          lastLen = 0, flushLen = 0, lastFlush = 0, riseAt = 0, launches = 0, t0 = 0;

	// ----
	// Design, host and clock
	// ----
	// Short counts keep the run brief
	adc_calibration_sequencer #(
		.STARTUP_SHORT_CYCLES(32'h0000_00C8), .STARTUP_LONG_CYCLES(32'h0000_0190),
		.TERM_CYCLES(32'h0000_0014), .LIN_CYCLES(32'h0000_0028)
	) u_adc_calibration_sequencer (
		.clock(clock), .rst(rst), .pins(pins), .regReq(regReq), .regRdata(regRdata),
		.regRvalid(regRvalid), .trimResultValid(trimResultValid),
		.trimResultData(trimResultData), .trimInProgress(trimInProgress),
		.termTrimActive(termTrimActive), .linearityTrimActive(linearityTrimActive),
		.outputsForcedLow(outputsForcedLow), .outputDataValid(outputDataValid),
		.firstChannelDown(firstChannelDown), .secondChannelDown(secondChannelDown),
		.deviceSuspended(deviceSuspended)
	);
	cal_host u_cal_host (
		.clock(clock), .trimInProgress(trimInProgress), .regRdata(regRdata),
		.pins(pins), .regReq(regReq)
	);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Run bookkeeping: launch time, busy and flush lengths, timeout
	always @(posedge clock) begin
		cycles <= cycles + 1;
		sinceRst <= rst ? 0 : sinceRst + 1;
		if (trimInProgress === 1'b1) busyLen <= busyLen + 1;
		else busyLen <= 0;
		if (trimInProgress === 1'b1 && busyLen == 0) riseAt <= sinceRst;
		if (trimInProgress === 1'b1 && busyLen == 0) launches <= launches + 1;
		if (trimInProgress !== 1'b1 && busyLen != 0) lastLen <= busyLen;
		if (outputsForcedLow === 1'b1 && trimInProgress !== 1'b1) flushLen <= flushLen + 1;
		if (outputsForcedLow !== 1'b1 && flushLen != 0) lastFlush <= flushLen;
		if (outputsForcedLow !== 1'b1) flushLen <= 0;
		if (cycles == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		total_checks++;
		if (seen !== expd) begin
			n_errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, expd);
		end
	endtask : check
	task automatic waitLaunch(input int k);
		for (int n = 0; n < 1000 && launches < k; n++) @(posedge clock);
	endtask : waitLaunch
	// Waits for run and flush to end, so counts have landed
	task automatic settle();
		for (int n = 0; n < 2000 && (trimInProgress !== 1'b0 || outputDataValid !== 1'b1); n++)
			@(posedge clock);
		repeat (2) @(posedge clock);
		#1;
	endtask : settle
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// ----
	// Test sequence
	// ----
	initial begin
		rst = 1'b1;
		trimResultValid = 1'b0;
		trimResultData = 16'h0000;
		repeat (20) @(posedge clock);
		#1 rst = 1'b0;
		waitLaunch(1);
		settle();
		check(riseAt >= 200 && riseAt <= 215, 1);
		check(lastLen, 60);
		check(lastFlush, 60);
		$display("power-on done");
		// Defaults, unmapped address, gated values port, register power-down
		u_cal_host.rd(`ADDR_CAL_ADJUST, rdv);
		check(rdv & 16'h4080, 16'h4000);
		u_cal_host.rd(4'hA, rdv);
		check(rdv, 0);
		u_cal_host.rd(`ADDR_CAL_VALUES, rdv);
		check(rdv, 0);
		u_cal_host.wr(`ADDR_CONFIG, 16'h0800);
		repeat (2) @(posedge clock);
		#1 check(firstChannelDown, 1);
		u_cal_host.wr(`ADDR_CONFIG, 16'h0000);
		$display("registers done");
		// Noise pulse ignored; long high gives one run only
		u_cal_host.request(1'b0, 40);
		repeat (150) @(posedge clock);
		check(launches, 1);
		u_cal_host.request(1'b0, 300);
		settle();
		check(launches, 2);
		check(lastLen, 60);
		$display("pin request done");
		u_cal_host.wr(`ADDR_CAL_ADJUST, 16'h0000);
		u_cal_host.request(1'b1, 100);
		settle();
		check(launches, 3);
		check(lastLen, 40);
		u_cal_host.wr(`ADDR_CAL_ADJUST, 16'h4000);
		$display("bit request done");
		// Both channels down for 30 cycles mid-run
		u_cal_host.request(1'b0, 100);
		u_cal_host.pins[2:1] = 2'h3;
		repeat (30) @(posedge clock);
		#1 check(deviceSuspended, 1);
		u_cal_host.pins[2:1] = 2'h0;
		settle();
		check(lastLen >= 86 && lastLen <= 94, 1);
		// Fresh run after the channels come back
		u_cal_host.request(1'b0, 100);
		settle();
		check(launches, 5);
		check(lastLen, 60);
		$display("power-down done");
		u_cal_host.restore(16'h1000);
		u_cal_host.wr(`ADDR_CAL_ADJUST, 16'h4080);
		for (int i = 0; i < 241; i++) begin
			u_cal_host.rd(`ADDR_CAL_VALUES, rdv);
			check(rdv, (i == 0 || i == 240) ? 0 : 32'h1000 + i);
		end
		u_cal_host.wr(`ADDR_CAL_ADJUST, 16'h4000);
		$display("store done");
		// Trim engine results land in the store during this run
		trimResultValid = 1'b1;
		trimResultData = 16'h2000;
		t0 = sinceRst;
		u_cal_host.pins[3] = 1'b1;
		waitLaunch(6);
		settle();
		trimResultValid = 1'b0;
		check(riseAt - t0 >= 400 && riseAt - t0 <= 415, 1);
		check(lastLen, 60);
		u_cal_host.wr(`ADDR_CAL_ADJUST, 16'h4080);
		u_cal_host.rd(`ADDR_CAL_VALUES, rdv);
		check(rdv, 0);
		u_cal_host.rd(`ADDR_CAL_VALUES, rdv);
		check(rdv, 32'h2000);
		u_cal_host.wr(`ADDR_CAL_ADJUST, 16'h4000);
		$display("delay select done");
		// Request held high through reset: no power-on run
		u_cal_host.pins[4] = 1'b1;
		rst = 1'b1;
		repeat (20) @(posedge clock);
		#1 rst = 1'b0;
		repeat (600) @(posedge clock);
		check(launches, 6);
		// Delay select moved while the request is held high
		u_cal_host.pins[3] = 1'b0;
		repeat (600) @(posedge clock);
		check(launches, 6);
		u_cal_host.request(1'b0, 100);
		settle();
		check(launches, 7);
		$display("held request done");
		wrap_up();
	end
endmodule : test_adc_calibration_sequencer
